// >>> core/rmtd_pkg.sv
// Package with register map, field positions and types of the receive mode and driver control block.
package rmtd_pkg;
   localparam logic [5:0] ADDR_RX_MODE = 6'h13;
   localparam logic [5:0] ADDR_DRV_CTRL = 6'h14;
   localparam logic [5:0] ADDR_ERROR_FLAGS = 6'h06;
   localparam logic [7:0] RST_RX_MODE = 8'h00;
   localparam logic [7:0] RST_DRV_CTRL = 8'h80;
   localparam logic [3:0] CMD_RECEIVE = 4'h8;
   localparam logic [3:0] CMD_TRANSCEIVE = 4'hC;
   localparam logic [3:0] CMD_IDLE = 4'h0;
   localparam int RX_RATE_LSB = 4;
   localparam int RX_IGNORE_BIT = 3;
   localparam int RX_MULTI_BIT = 2;
   localparam int RX_FRAMING_LSB = 0;
   localparam int DC_INV2_ON = 7;
   localparam int DC_INV1_ON = 6;
   localparam int DC_INV2_OFF = 5;
   localparam int DC_INV1_OFF = 4;
   localparam int DC_CW2 = 3;
   localparam int DC_INTERLOCK = 2;
   localparam int DC_EN2 = 1;
   localparam int DC_EN1 = 0;
   localparam logic [2:0] SHORT_FRAME_BITS = 3'h4;
   localparam logic [7:0] RSV_MASK_READ = 8'hFB;

   typedef enum logic [2:0]
   {
      RMTD_RATE_106,
      RMTD_RATE_212,
      RMTD_RATE_424,
      RMTD_RATE_848,
      RMTD_RATE_1696,
      RMTD_RATE_3392,
      RMTD_RATE_RSV6,
      RMTD_RATE_RSV7
   } rmtd_rate_e;

   typedef enum logic [1:0]
   {
      RMTD_FRM_A106,
      RMTD_FRM_ACTIVE,
      RMTD_FRM_PASSIVE_HI,
      RMTD_FRM_B
   } rmtd_framing_e;

   // Register read and write request from the host interface.
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } rmtd_reg_req_s;

   // End-of-stream report from the receive decoder.
   typedef struct packed
   {
      logic done;
      logic valid;
      logic [7:0] nbits;
   } rmtd_rx_end_s;
endpackage

// >>> core/rmtd_err_byte.sv
// Holding register that presents the error byte appended to the FIFO after a stream.
`timescale 1ns/1ps
`default_nettype none
module rmtd_err_byte
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic load,
   input wire logic [7:0] err_in,
   output logic push,
   output logic [7:0] data
);
   logic next_push;
   logic [7:0] next_data;

   // Capture the error flags when the stream ends so the FIFO sees a stable copy.
   always_comb
   begin
      next_push = load;
      next_data = load ? err_in : data;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         push <= 1'b0;
         data <= 8'h00;
      end
      else
      begin
         push <= next_push;
         data <= next_data;
      end
   end
endmodule
`default_nettype wire

// >>> core/rmtd_ctrl.sv
// Receive mode configuration and antenna driver control registers with receiver sequencing.
// What this block does
// - The three-bit receive rate field selects 106, 212, 424, 848, 1696 or 3392 kbit, codes 110 and 111 reserved.
// - Above 424 kbit the receiver uses the 424 kbit active-mode bit coding.
// - With the ignore bit set, an invalid stream shorter than four bits is dropped and the receiver stays on.
// - With type B framing an invalid stream is only ignored if start of frame required is also set.
// - With multi-frame receive clear, the receiver turns off after one frame.
// - With multi-frame receive set, frames keep coming and receive or transceive do not end on their own.
// - Multi-frame reception ends only on a command other than Receive or Transceive, or on clearing the multi-frame bit.
// - In multi-frame mode each stream not dropped as short ends with one FIFO byte copied from the error flags register.
// - A two-bit field selects the expected framing: type A 106, active, passive 212/424 or type B.
// - Enabled-state inversion bits 7 and 6 invert drivers 2 and 1 while that driver is enabled.
// - Disabled-state inversion bits 5 and 4 invert drivers 2 and 1 while that driver is disabled.
// - Driver 2 continuous-carrier bit 3 sends unmodulated carrier, clear lets it be modulated.
// - With the write-only interlock bit set, writes setting a carrier enable are refused while a field is seen.
// - Carrier enable bits 1 and 0 make drivers 2 and 1 send carrier modulated by transmit data.
// - The driver control register sits at 14h and resets to 80h.
`timescale 1ns/1ps
`default_nettype none
module rmtd_ctrl
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire rmtd_pkg::rmtd_reg_req_s reg_req,
   input wire logic cmd_write,
   input wire logic [3:0] cmd_code,
   input wire logic start_of_frame_required,
   input wire logic [7:0] error_flags_register,
   input wire rmtd_pkg::rmtd_rx_end_s rx_end,
   input wire logic ext_field_detected,
   input wire logic carrier,
   input wire logic tx_mod,
   output logic [7:0] reg_rdata,
   output logic rx_active,
   output logic [2:0] rx_rate,
   output logic rx_coding_active424,
   output logic [1:0] rx_framing,
   output logic rx_frame_drop,
   output logic fifo_push,
   output logic [7:0] fifo_data,
   output logic antenna_driver_pin_one,
   output logic antenna_driver_pin_two
);
   logic [7:0] receive_mode_config;
   logic [7:0] antenna_driver_control;
   logic [7:0] next_receive_mode_config;
   logic [7:0] next_antenna_driver_control;
   logic [7:0] next_reg_rdata;
   logic next_rx_active;
   logic next_rx_frame_drop;
   logic [2:0] next_rx_rate;
   logic next_coding;
   logic [1:0] next_rx_framing;
   logic next_pin1;
   logic next_pin2;
   logic multi;
   logic ignore_ok;
   logic short_bad;
   logic err_load;
   logic [7:0] wd;

   assign multi = receive_mode_config[rmtd_pkg::RX_MULTI_BIT];
   assign wd = reg_req.wdata;
   // Type B needs start of frame required before a short bad stream may be ignored.
   assign ignore_ok = receive_mode_config[rmtd_pkg::RX_IGNORE_BIT] &&
      ((receive_mode_config[1:0] != rmtd_pkg::RMTD_FRM_B) || start_of_frame_required);
   assign short_bad = rx_end.done && !rx_end.valid && (rx_end.nbits < {5'h00, rmtd_pkg::SHORT_FRAME_BITS});
   assign err_load = rx_end.done && multi && !(short_bad && ignore_ok) && rx_active;

   // Register writes; the interlock bit of the written byte gates the enable bits of that same write.
   always_comb
   begin
      next_receive_mode_config = receive_mode_config;
      next_antenna_driver_control = antenna_driver_control;
      if (reg_req.wr && reg_req.addr == rmtd_pkg::ADDR_RX_MODE)
      begin
         next_receive_mode_config = wd;
      end
      if (reg_req.wr && reg_req.addr == rmtd_pkg::ADDR_DRV_CTRL)
      begin
         next_antenna_driver_control = wd;
         // A refused write leaves each enable bit as it was rather than forcing it off.
         if (wd[rmtd_pkg::DC_INTERLOCK] && ext_field_detected)
         begin
            if (wd[rmtd_pkg::DC_EN2] && !antenna_driver_control[rmtd_pkg::DC_EN2])
            begin
               next_antenna_driver_control[rmtd_pkg::DC_EN2] = 1'b0;
            end
            if (wd[rmtd_pkg::DC_EN1] && !antenna_driver_control[rmtd_pkg::DC_EN1])
            begin
               next_antenna_driver_control[rmtd_pkg::DC_EN1] = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         receive_mode_config <= rmtd_pkg::RST_RX_MODE;
         antenna_driver_control <= rmtd_pkg::RST_DRV_CTRL;
      end
      else
      begin
         receive_mode_config <= next_receive_mode_config;
         antenna_driver_control <= next_antenna_driver_control;
      end
   end

   // Receiver on/off sequencing and the configuration it presents to the decoder.
   always_comb
   begin
      next_rx_active = rx_active;
      next_rx_frame_drop = 1'b0;
      next_rx_rate = receive_mode_config[6:4];
      next_coding = (receive_mode_config[6:4] > rmtd_pkg::RMTD_RATE_424) &&
         (receive_mode_config[6:4] <= rmtd_pkg::RMTD_RATE_3392);
      next_rx_framing = receive_mode_config[1:0];
      if (rx_active && rx_end.done)
      begin
         if (short_bad && ignore_ok)
         begin
            next_rx_frame_drop = 1'b1;
         end
         else if (!multi)
         begin
            next_rx_active = 1'b0;
         end
      end
      if (rx_active && multi && reg_req.wr && reg_req.addr == rmtd_pkg::ADDR_RX_MODE && !wd[rmtd_pkg::RX_MULTI_BIT])
      begin
         next_rx_active = 1'b0;
      end
      if (cmd_write)
      begin
         // Any other command stops reception; multi mode never ends by itself.
         next_rx_active = (cmd_code == rmtd_pkg::CMD_RECEIVE) || (cmd_code == rmtd_pkg::CMD_TRANSCEIVE);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_active <= 1'b0;
         rx_frame_drop <= 1'b0;
         rx_rate <= 3'h0;
         rx_coding_active424 <= 1'b0;
         rx_framing <= 2'h0;
      end
      else
      begin
         rx_active <= next_rx_active;
         rx_frame_drop <= next_rx_frame_drop;
         rx_rate <= next_rx_rate;
         rx_coding_active424 <= next_coding;
         rx_framing <= next_rx_framing;
      end
   end

   // Driver pin levels; outputs are registered so pins lag the carrier by one clock.
   always_comb
   begin
      logic en1;
      logic en2;
      logic base1;
      logic base2;
      en1 = antenna_driver_control[rmtd_pkg::DC_EN1];
      en2 = antenna_driver_control[rmtd_pkg::DC_EN2];
      base1 = en1 && carrier && tx_mod;
      base2 = en2 && carrier && (tx_mod || antenna_driver_control[rmtd_pkg::DC_CW2]);
      next_pin1 = base1 ^ (en1 ? antenna_driver_control[rmtd_pkg::DC_INV1_ON]
         : antenna_driver_control[rmtd_pkg::DC_INV1_OFF]);
      next_pin2 = base2 ^ (en2 ? antenna_driver_control[rmtd_pkg::DC_INV2_ON]
         : antenna_driver_control[rmtd_pkg::DC_INV2_OFF]);
      next_reg_rdata = 8'h00;
      if (reg_req.addr == rmtd_pkg::ADDR_RX_MODE)
      begin
         next_reg_rdata = receive_mode_config;
      end
      else if (reg_req.addr == rmtd_pkg::ADDR_DRV_CTRL)
      begin
         next_reg_rdata = antenna_driver_control & rmtd_pkg::RSV_MASK_READ;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // Driver 2 is disabled at reset with its disabled-state inversion clear, so the pin idles low.
         antenna_driver_pin_one <= 1'b0;
         antenna_driver_pin_two <= 1'b0;
         reg_rdata <= 8'h00;
      end
      else
      begin
         antenna_driver_pin_one <= next_pin1;
         antenna_driver_pin_two <= next_pin2;
         reg_rdata <= next_reg_rdata;
      end
   end

   // Error byte holder for multi-frame reception.
   rmtd_err_byte u_err
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .load(err_load),
      .err_in(error_flags_register),
      .push(fifo_push),
      .data(fifo_data)
   );

   property p_reset_value;
      @(posedge sys_clk) $rose(arst_n) |-> antenna_driver_control == rmtd_pkg::RST_DRV_CTRL;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("Driver control reset value wrong.");

   property p_interlock;
      @(posedge sys_clk) disable iff (!arst_n)
      reg_req.wr && reg_req.addr == rmtd_pkg::ADDR_DRV_CTRL && wd[2] && ext_field_detected && wd[0]
         && !antenna_driver_control[0] |=> !antenna_driver_control[0];
   endproperty
   a_interlock: assert property (p_interlock) else $error("Enable set despite external field.");

   property p_read_wo;
      @(posedge sys_clk) disable iff (!arst_n)
      reg_req.addr == rmtd_pkg::ADDR_DRV_CTRL |=> !reg_rdata[2];
   endproperty
   a_read_wo: assert property (p_read_wo) else $error("Interlock bit read back nonzero.");

   property p_single_off;
      @(posedge sys_clk) disable iff (!arst_n)
      rx_active && rx_end.done && !multi && !(short_bad && ignore_ok) && !cmd_write |=> !rx_active;
   endproperty
   a_single_off: assert property (p_single_off) else $error("Receiver stayed on after single frame.");

   property p_multi_on;
      @(posedge sys_clk) disable iff (!arst_n)
      rx_active && multi && !cmd_write && !reg_req.wr |=> rx_active;
   endproperty
   a_multi_on: assert property (p_multi_on) else $error("Multi-frame receive ended on its own.");

   sequence s_stop_cmd;
      cmd_write && cmd_code != rmtd_pkg::CMD_RECEIVE && cmd_code != rmtd_pkg::CMD_TRANSCEIVE;
   endsequence
   property p_stop_cmd;
      @(posedge sys_clk) disable iff (!arst_n) s_stop_cmd |=> !rx_active;
   endproperty
   a_stop_cmd: assert property (p_stop_cmd) else $error("Other command did not stop reception.");

   property p_err_byte;
      @(posedge sys_clk) disable iff (!arst_n)
      err_load |-> ##1 fifo_push && fifo_data == $past(error_flags_register);
   endproperty
   a_err_byte: assert property (p_err_byte) else $error("Error byte not appended.");

   property p_ignore;
      @(posedge sys_clk) disable iff (!arst_n)
      rx_active && short_bad && ignore_ok && !cmd_write && !reg_req.wr |=> rx_active && rx_frame_drop;
   endproperty
   a_ignore: assert property (p_ignore) else $error("Short invalid stream not ignored.");

   property p_inv_off;
      @(posedge sys_clk) disable iff (!arst_n)
      !antenna_driver_control[0] |=> antenna_driver_pin_one == $past(antenna_driver_control[4]);
   endproperty
   a_inv_off: assert property (p_inv_off) else $error("Disabled driver 1 level wrong.");

   property p_rate;
      @(posedge sys_clk) disable iff (!arst_n)
      ##1 rx_rate == $past(receive_mode_config[6:4]) && rx_coding_active424 == ($past(receive_mode_config[6:4]) inside {3'h3, 3'h4, 3'h5});
   endproperty
   a_rate: assert property (p_rate) else $error("Receive rate decode wrong.");
endmodule
`default_nettype wire

// >>> verif/rmtd_card_model.sv
// Far-side peer whose RF field is seen by the level detector of the device.
`timescale 1ns/1ps
`default_nettype none
module rmtd_card_model
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic field_on,
   output logic ext_field_detected
);
   // The detector lags the peer field by one cycle, as a filtered level would.
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         ext_field_detected <= 1'b0;
      else
         ext_field_detected <= field_on;
   end
endmodule
`default_nettype wire

// >>> verif/test_rx_mode_tx_driver_control.sv
// Self-checking bench for the receive mode and antenna driver control block.
`timescale 1ns/1ps
`default_nettype none
module test_rx_mode_tx_driver_control;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   rmtd_pkg::rmtd_reg_req_s reg_req = '0;
   rmtd_pkg::rmtd_rx_end_s rx_end = '0;
   logic cmd_write = 1'b0;
   logic [3:0] cmd_code = 4'h0;
   logic sof = 1'b0;
   logic [7:0] eflags = 8'h00;
   logic field_on = 1'b0;
   logic ext_field;
   logic carrier = 1'b0;
   logic tx_mod = 1'b0;
   logic [7:0] reg_rdata;
   logic [7:0] fifo_data;
   logic [2:0] rx_rate;
   logic [1:0] rx_framing;
   logic rx_active, rx_c424, rx_frame_drop, fifo_push, pin1, pin2;
   int errors = 0;
   int checks_done = 0;
   logic [7:0] exp_q[$];

   rmtd_ctrl uut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_req(reg_req), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .start_of_frame_required(sof), .error_flags_register(eflags), .rx_end(rx_end),
      .ext_field_detected(ext_field), .carrier(carrier), .tx_mod(tx_mod), .reg_rdata(reg_rdata),
      .rx_active(rx_active), .rx_rate(rx_rate), .rx_coding_active424(rx_c424), .rx_framing(rx_framing),
      .rx_frame_drop(rx_frame_drop), .fifo_push(fifo_push), .fifo_data(fifo_data),
      .antenna_driver_pin_one(pin1), .antenna_driver_pin_two(pin2));
   rmtd_card_model peer (.sys_clk(sys_clk), .arst_n(arst_n), .field_on(field_on), .ext_field_detected(ext_field));

   // Free-running 25 MHz clock.
   always #20 sys_clk = ~sys_clk;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      reg_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_req.addr <= a;
      tick(2);
      #1 chk(reg_rdata, e);
   endtask

   task automatic cmd(input logic [3:0] c);
      @(posedge sys_clk);
      cmd_write <= 1'b1;
      cmd_code <= c;
      @(posedge sys_clk);
      cmd_write <= 1'b0;
      tick(2);
      #1;
   endtask

   // Drop pulses are gathered over a few cycles, since the note fixes only a one-cycle pulse.
   task automatic stream(input logic [7:0] n, input logic v, input logic drop);
      logic seen;
      seen = 1'b0;
      @(posedge sys_clk);
      rx_end <= '{done: 1'b1, valid: v, nbits: n};
      @(posedge sys_clk);
      rx_end.done <= 1'b0;
      // The drop pulse is launched at this edge and stands for one cycle only.
      #1 seen = rx_frame_drop;
      repeat (3)
      begin
         @(posedge sys_clk);
         #1 seen = seen | rx_frame_drop;
      end
      chk({7'h00, seen}, {7'h00, drop});
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Each error byte pushed must match the oldest flags value noted by the driver.
   always @(posedge sys_clk)
   begin
      if (fifo_push === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk(fifo_data, 8'hXX);
         else
            chk(fifo_data, exp_q.pop_front());
      end
   end

   // Main sequence.
   initial
   begin
      logic [7:0] c;
      logic m;
      void'($urandom(32'hAD92));
      tick(2);
      arst_n <= 1'b1;
      rd(6'h14, 8'h80);
      rd(6'h13, 8'h00);
      rd(6'h3F, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 32; i++)
      begin
         wr(6'h13, {1'b0, 3'(i >> 2), 2'b00, 2'(i)});
         tick(2);
         #1 chk({5'h00, rx_rate}, 8'(i >> 2));
         chk({7'h00, rx_c424}, {7'h00, (i >> 2) inside {3, 4, 5}});
         chk({6'h00, rx_framing}, 8'(i & 3));
      end
      $display("test rate and framing done");
      wr(6'h13, 8'h08);
      cmd(rmtd_pkg::CMD_RECEIVE);
      stream(8'h03, 1'b0, 1'b1);
      chk({7'h00, rx_active}, 8'h01);
      stream(8'h04, 1'b0, 1'b0);
      chk({7'h00, rx_active}, 8'h00);
      wr(6'h13, 8'h0B);
      cmd(rmtd_pkg::CMD_TRANSCEIVE);
      stream(8'h03, 1'b0, 1'b0);
      chk({7'h00, rx_active}, 8'h00);
      @(posedge sys_clk);
      sof <= 1'b1;
      cmd(rmtd_pkg::CMD_RECEIVE);
      stream(8'h03, 1'b0, 1'b1);
      $display("test short frames done");
      wr(6'h13, 8'h0C);
      cmd(rmtd_pkg::CMD_RECEIVE);
      stream(8'h02, 1'b0, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         @(posedge sys_clk);
         eflags <= 8'($urandom);
         @(posedge sys_clk);
         exp_q.push_back(eflags);
         stream(8'h10, 1'(k), 1'b0);
         chk({7'h00, rx_active}, 8'h01);
      end
      cmd(rmtd_pkg::CMD_RECEIVE);
      chk({7'h00, rx_active}, 8'h01);
      cmd(rmtd_pkg::CMD_IDLE);
      chk({7'h00, rx_active}, 8'h00);
      cmd(rmtd_pkg::CMD_TRANSCEIVE);
      wr(6'h13, 8'h08);
      tick(2);
      #1 chk({7'h00, rx_active}, 8'h00);
      $display("test multi frame done");
      for (int k = 0; k < 24; k++)
      begin
         c = 8'($urandom) & 8'hFB;
         wr(6'h14, c);
         @(posedge sys_clk);
         carrier <= 1'($urandom);
         tx_mod <= 1'($urandom);
         tick(3);
         #1 m = carrier & tx_mod;
         chk({7'h00, pin1}, {7'h00, c[0] ? m ^ c[6] : c[4]});
         chk({7'h00, pin2}, {7'h00, c[1] ? (c[3] ? carrier : m) ^ c[7] : c[5]});
         rd(6'h14, c);
      end
      $display("test drivers done");
      wr(6'h14, 8'h00);
      @(posedge sys_clk);
      field_on <= 1'b1;
      tick(2);
      wr(6'h14, 8'h07);
      rd(6'h14, 8'h00);
      wr(6'h14, 8'h03);
      rd(6'h14, 8'h03);
      wr(6'h14, 8'h07);
      rd(6'h14, 8'h03);
      @(posedge sys_clk);
      field_on <= 1'b0;
      wr(6'h14, 8'h00);
      tick(2);
      wr(6'h14, 8'h07);
      rd(6'h14, 8'h03);
      $display("test interlock done");
      for (int t = 0; t < 20 && exp_q.size() != 0; t++)
         tick(1);
      if (exp_q.size() != 0)
      begin
         errors++;
         $display("[ERR] %0t error bytes missing", $time);
      end
      final_report();
   end
endmodule
`default_nettype wire
